// ---- rtl/adcseq_pkg.sv ----
// constants and types shared by the conversion sequencer files
package adcseq_pkg;
    localparam int unsigned SAMPLE_CLOCKS   = 4;
    localparam int unsigned CONVERT_CLOCKS  = 12;
    localparam int unsigned TOTAL_CLOCKS    = SAMPLE_CLOCKS + CONVERT_CLOCKS;
    localparam int unsigned RESULT_WIDTH    = 12;
    localparam int unsigned DIV_SEL_WIDTH   = 3;
    localparam int unsigned PRESCALE_WIDTH  = 7;
    localparam logic [11:0] FULL_SCALE_CODE = 12'hfff;
    localparam logic [2:0]  SRC_BANDGAP     = 3'h1;
    localparam logic [2:0]  SRC_EXT_A       = 3'h0;
    localparam logic [2:0]  SRC_EXT_B       = 3'h5;
    localparam logic [7:0]  RESULT_RESET    = 8'h00;
    localparam logic [4:0]  CLOCK_CNT_RESET = 5'h00;

    typedef enum {
        ADCSEQ_IDLE,
        ADCSEQ_ARMED,
        ADCSEQ_SAMPLE,
        ADCSEQ_CONVERT
    } adcseq_state_t;
endpackage : adcseq_pkg

// ---- rtl/adcseq_clock_divider.sv ----
// converter clock tick generator, system clock divided by a power of two
`timescale 1ns/1ns
module adcseq_clock_divider #(
    parameter int unsigned SEL_WIDTH = adcseq_pkg::DIV_SEL_WIDTH,
    parameter int unsigned CNT_WIDTH = adcseq_pkg::PRESCALE_WIDTH
) (
    input  wire logic                 sys_clk,
    input  wire logic                 reset_n,
    input  wire logic                 run,
    input  wire logic [SEL_WIDTH-1:0] divider_sel,
    output logic                      tick
);
    if (CNT_WIDTH != (1 << SEL_WIDTH) - 1) begin : g_width_check
        $error("prescaler width does not match selector width");
    end

    typedef struct packed {
        logic [CNT_WIDTH-1:0] count;
    } adcseq_div_state_t;

    adcseq_div_state_t state_reg;
    adcseq_div_state_t state_next;
    logic [CNT_WIDTH-1:0] mask;

    // divide by two to the power of the code
    always_comb begin
        mask = CNT_WIDTH'((1 << divider_sel) - 1);
        state_next = state_reg;
        if (!run || ((state_reg.count & mask) == mask)) begin
            state_next.count = '0;
        end else begin
            state_next.count = state_reg.count + 1'b1;
        end
    end

    assign tick = run && ((state_reg.count & mask) == mask);

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end
endmodule : adcseq_clock_divider

// ---- rtl/adcseq_sequencer.sv ----
// conversion sequencer: start detect, sample and convert phases, result bytes
//
// Summary of operation
// - sample for 4 converter clocks, convert for 12, 16 in total.
// - after start the conversion runs alone in hardware until done.
// - source codes 000, 101, 11x route the chosen external channel.
// - format bit picks alignment of the 12-bit result across two bytes.
// - start bit low, high, low starts a conversion.
// - busy high during conversion, low at completion with valid result.
// - codes are 12-bit unsigned, full scale fff.
// - power enable low switches the converter off.
// - divider code selects system clock divided by 1 up to 128.
// - completion sets the interrupt flag and, if enabled, raises interrupt.
`timescale 1ns/1ns
module adcseq_sequencer #(
    parameter int unsigned RES_WIDTH = adcseq_pkg::RESULT_WIDTH
) (
    input  wire logic                 sys_clk,
    input  wire logic                 reset_n,
    input  wire logic                 converter_power_enable,
    input  wire logic [2:0]           conv_clock_divider_sel,
    input  wire logic [2:0]           input_source_sel,
    input  wire logic [3:0]           external_channel_sel,
    input  wire logic                 result_format_sel,
    input  wire logic                 start_bit,
    input  wire logic                 global_interrupt_enable,
    input  wire logic                 converter_interrupt_enable,
    input  wire logic                 interrupt_flag_clear,
    input  wire logic [RES_WIDTH-1:0] analog_code,
    output logic                      converter_powered,
    output logic                      sample_hold,
    output logic                      external_route_enable,
    output logic [2:0]                external_channel_route,
    output logic                      bandgap_route_enable,
    output logic                      conversion_busy_flag,
    output logic                      converter_interrupt_flag,
    output logic                      interrupt_request,
    output logic [7:0]                result_high_byte,
    output logic [7:0]                result_low_byte
);
    // ****************************************************************
    // parameter checks
    // ****************************************************************
    // the byte split below assumes a 12-bit code
    if (RES_WIDTH != 12) begin : g_width_check
        $error("result alignment is built for a 12-bit converter");
    end
    // the phase counter must hold the whole conversion
    if (adcseq_pkg::TOTAL_CLOCKS > 31) begin : g_count_check
        $error("phase counter too narrow for the conversion length");
    end

    localparam logic [4:0] SAMPLE_LAST = 5'(adcseq_pkg::SAMPLE_CLOCKS - 1);
    localparam logic [4:0] TOTAL_LAST  = 5'(adcseq_pkg::TOTAL_CLOCKS - 1);

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        adcseq_pkg::adcseq_state_t phase;
        logic [4:0]                clocks;
        logic                      start_prev;
        logic                      busy;
        logic                      irq_flag;
        logic [7:0]                res_high;
        logic [7:0]                res_low;
    } adcseq_seq_state_t;

    adcseq_seq_state_t state_reg;
    adcseq_seq_state_t state_next;
    logic              conv_tick;
    logic              divider_run;
    logic              conv_done;

    // ****************************************************************
    // phase helpers
    // ****************************************************************
    function automatic logic phase_is_running(input adcseq_pkg::adcseq_state_t ph);
        phase_is_running = (ph == adcseq_pkg::ADCSEQ_SAMPLE) ||
                           (ph == adcseq_pkg::ADCSEQ_CONVERT);
    endfunction : phase_is_running

    // divider held cleared between conversions so each one starts aligned
    assign divider_run = phase_is_running(state_reg.phase);

    // ****************************************************************
    // converter clock
    // ****************************************************************
    adcseq_clock_divider #(
        .SEL_WIDTH (adcseq_pkg::DIV_SEL_WIDTH),
        .CNT_WIDTH (adcseq_pkg::PRESCALE_WIDTH)
    ) u_divider (
        .sys_clk     (sys_clk),
        .reset_n     (reset_n),
        .run         (divider_run),
        .divider_sel (conv_clock_divider_sel),
        .tick        (conv_tick)
    );

    // ****************************************************************
    // input routing
    // ****************************************************************
    function automatic logic source_is_external(input logic [2:0] src);
        // external sources are 000, 101, 11x
        source_is_external = (src == adcseq_pkg::SRC_EXT_A) ||
                             (src == adcseq_pkg::SRC_EXT_B) || (src[2:1] == 2'b11);
    endfunction : source_is_external

    // channel routed only for external sources with msb clear
    assign external_route_enable  = converter_power_enable &&
                                    source_is_external(input_source_sel) &&
                                    !external_channel_sel[3];
    assign external_channel_route = external_channel_sel[2:0];
    assign bandgap_route_enable   = converter_power_enable &&
                                    (input_source_sel == adcseq_pkg::SRC_BANDGAP);
    // power enable low switches the analog circuitry off
    assign converter_powered      = converter_power_enable;
    assign sample_hold            = state_reg.phase == adcseq_pkg::ADCSEQ_SAMPLE;

    // ****************************************************************
    // sequence
    // ****************************************************************
    // last converter clock of the convert phase
    assign conv_done = (state_reg.phase == adcseq_pkg::ADCSEQ_CONVERT) && conv_tick &&
                       (state_reg.clocks == TOTAL_LAST);

    always_comb begin
        state_next = state_reg;
        state_next.start_prev = start_bit;
        unique case (state_reg.phase)
            adcseq_pkg::ADCSEQ_IDLE: begin
                if (start_bit && !state_reg.start_prev && converter_power_enable) begin
                    state_next.phase = adcseq_pkg::ADCSEQ_ARMED;
                end
            end
            adcseq_pkg::ADCSEQ_ARMED: begin
                // falling edge starts sampling and sets busy
                if (!start_bit) begin
                    state_next.phase  = adcseq_pkg::ADCSEQ_SAMPLE;
                    state_next.clocks = adcseq_pkg::CLOCK_CNT_RESET;
                    state_next.busy   = 1'b1;
                end
            end
            adcseq_pkg::ADCSEQ_SAMPLE: begin
                if (conv_tick) begin
                    state_next.clocks = state_reg.clocks + 5'h01;
                    if (state_reg.clocks == SAMPLE_LAST) begin
                        state_next.phase = adcseq_pkg::ADCSEQ_CONVERT;
                    end
                end
            end
            adcseq_pkg::ADCSEQ_CONVERT: begin
                // twelve clocks, completes without software help
                if (conv_tick) begin
                    state_next.clocks = state_reg.clocks + 5'h01;
                    if (state_reg.clocks == TOTAL_LAST) begin
                        state_next.phase = adcseq_pkg::ADCSEQ_IDLE;
                        state_next.busy  = 1'b0;
                        // latch 12-bit unsigned code with chosen alignment
                        if (result_format_sel) begin
                            state_next.res_high = {4'h0, analog_code[11:8]};
                            state_next.res_low  = analog_code[7:0];
                        end else begin
                            state_next.res_high = analog_code[11:4];
                            state_next.res_low  = {analog_code[3:0], 4'h0};
                        end
                    end
                end
            end
        endcase
        if (!converter_power_enable) begin
            state_next.phase = adcseq_pkg::ADCSEQ_IDLE;
            state_next.busy  = 1'b0;
        end
        // completion sets the flag; set wins over clear
        if (conv_done && converter_power_enable) begin
            state_next.irq_flag = 1'b1;
        end else if (interrupt_flag_clear) begin
            state_next.irq_flag = 1'b0;
        end
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            state_reg.phase      <= adcseq_pkg::ADCSEQ_IDLE;
            state_reg.clocks     <= adcseq_pkg::CLOCK_CNT_RESET;
            state_reg.start_prev <= 1'b0;
            state_reg.busy       <= 1'b0;
            state_reg.irq_flag   <= 1'b0;
            state_reg.res_high   <= adcseq_pkg::RESULT_RESET;
            state_reg.res_low    <= adcseq_pkg::RESULT_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // ****************************************************************
    // status and result outputs
    // ****************************************************************
    // busy and result bytes straight from registers
    assign conversion_busy_flag     = state_reg.busy;
    assign converter_interrupt_flag = state_reg.irq_flag;
    assign result_high_byte         = state_reg.res_high;
    assign result_low_byte          = state_reg.res_low;

    // ****************************************************************
    // interrupt request
    // ****************************************************************
    // interrupt gated by both enables
    assign interrupt_request        = state_reg.irq_flag && converter_interrupt_enable &&
                                      global_interrupt_enable;
endmodule : adcseq_sequencer

// ---- tb/adcseq_checker.sv ----
// port assertions for the conversion sequencer
`timescale 1ns/1ns
module adcseq_checker (
    input wire logic       sys_clk,
    input wire logic       reset_n,
    input wire logic       converter_power_enable,
    input wire logic [2:0] conv_clock_divider_sel,
    input wire logic [2:0] input_source_sel,
    input wire logic [3:0] external_channel_sel,
    input wire logic       start_bit,
    input wire logic       global_interrupt_enable,
    input wire logic       converter_interrupt_enable,
    input wire logic       interrupt_flag_clear,
    input wire logic       sample_hold,
    input wire logic       external_route_enable,
    input wire logic [2:0] external_channel_route,
    input wire logic       bandgap_route_enable,
    input wire logic       conversion_busy_flag,
    input wire logic       converter_interrupt_flag,
    input wire logic       interrupt_request,
    input wire logic [7:0] result_high_byte,
    input wire logic [7:0] result_low_byte
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    a_start_busy: assert property ($fell(start_bit) && !conversion_busy_flag
        && converter_power_enable && $past(converter_power_enable) |=> conversion_busy_flag)
        else $error("busy did not follow start pulse");
    a_busy_span: assert property ($rose(conversion_busy_flag) && conv_clock_divider_sel == 3'h0
        |-> conversion_busy_flag [*8] ##1 conversion_busy_flag [*8] ##1 !conversion_busy_flag)
        else $error("busy span not sixteen cycles");
    a_sample_span: assert property ($rose(conversion_busy_flag) && conv_clock_divider_sel == 3'h0
        |-> sample_hold [*4] ##1 !sample_hold) else $error("sampling span not four cycles");
    a_flag_at_done: assert property ($rose(converter_interrupt_flag)
        |-> $fell(conversion_busy_flag)) else $error("flag set outside completion");
    a_result_stable: assert property (!$fell(conversion_busy_flag)
        |-> $stable(result_high_byte) && $stable(result_low_byte)) else $error("result moved");
    a_irq_gate: assert property (interrupt_request == (converter_interrupt_flag
        && global_interrupt_enable && converter_interrupt_enable)) else $error("irq gating wrong");
    a_flag_sticky: assert property (converter_interrupt_flag && !interrupt_flag_clear
        |=> converter_interrupt_flag) else $error("flag dropped without clear");
    a_ext_route: assert property (input_source_sel inside {3'h0, 3'h5, 3'h6, 3'h7}
        && !external_channel_sel[3] |-> external_route_enable == converter_power_enable
        && external_channel_route == external_channel_sel[2:0]) else $error("channel route wrong");
    a_bg_route: assert property (input_source_sel == 3'h1
        |-> bandgap_route_enable && !external_route_enable) else $error("bandgap route wrong");
    a_power_abort: assert property (!converter_power_enable
        |-> ##[1:2] !conversion_busy_flag) else $error("busy kept while unpowered");
    c_done: cover property ($rose(converter_interrupt_flag));
    c_abort: cover property ($fell(conversion_busy_flag) && !converter_power_enable);
    c_irq: cover property (interrupt_request);
endmodule : adcseq_checker

bind adcseq_sequencer adcseq_checker u_adcseq_checker (.*);

// ---- tb/adcseq_analog_model.sv ----
// analog side model: channel levels, bandgap level, ground
`timescale 1ns/1ns
module adcseq_analog_model #(
    parameter logic [11:0] BANDGAP_CODE = 12'h4c3
) (
    input wire logic        sys_clk,
    input wire logic        converter_powered,
    input wire logic        sample_hold,
    input wire logic        external_route_enable,
    input wire logic [2:0]  external_channel_route,
    input wire logic        bandgap_route_enable,
    output logic     [11:0] analog_code
);
    logic [11:0] level;
    // routed pin level, channel 7 full scale
    always_comb begin
        level = 12'h000;
        if (bandgap_route_enable) begin
            level = BANDGAP_CODE;
        end
        if (external_route_enable) begin
            level = {external_channel_route, 9'h1ff};
        end
    end
    initial analog_code = 12'h000;
    always @(posedge sys_clk) begin
        if (!converter_powered) begin
            analog_code <= ~analog_code;
        end else if (sample_hold) begin
            analog_code <= level;
        end
    end
endmodule : adcseq_analog_model

// ---- tb/adc_conversion_sequencer_tb.sv ----
// self-checking bench for the conversion sequencer
`timescale 1ns/1ns
module adc_conversion_sequencer_tb;
    localparam logic [11:0] BG = 12'h4c3;
    logic sys_clk = 1'h0, reset_n = 1'h0, converter_power_enable = 1'h0, start_bit = 1'h0;
    logic result_format_sel = 1'h0, global_interrupt_enable = 1'h0, interrupt_flag_clear = 1'h0;
    logic converter_interrupt_enable = 1'h0;
    logic [2:0] conv_clock_divider_sel = 3'h0, input_source_sel = 3'h0;
    logic [3:0] external_channel_sel = 4'h0;
    logic converter_powered, sample_hold, external_route_enable, bandgap_route_enable;
    logic conversion_busy_flag, converter_interrupt_flag, interrupt_request;
    logic [2:0] external_channel_route;
    logic [11:0] analog_code;
    logic [7:0] result_high_byte, result_low_byte;
    int n_errors = 0, checked = 0, span;

    adcseq_sequencer u_adcseq_sequencer (.*);
    adcseq_analog_model #(.BANDGAP_CODE(BG)) u_adcseq_analog_model (.*);
    always #2 sys_clk = ~sys_clk;

    task automatic chk(input string nm, input logic [19:0] seen, input logic [19:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    function automatic logic [15:0] aligned(input logic [11:0] c, input logic f);
        return f ? {4'h0, c} : {c, 4'h0};
    endfunction : aligned
    task automatic pulse;
        @(negedge sys_clk) start_bit = 1'h1;
        @(negedge sys_clk) start_bit = 1'h0;
    endtask : pulse
    task automatic clear_flag;
        interrupt_flag_clear = 1'h1;
        @(negedge sys_clk) interrupt_flag_clear = 1'h0;
    endtask : clear_flag
    task automatic convert;
        span = 0;
        pulse();
        @(negedge sys_clk);
        // busy counted at every falling edge until it drops
        while (conversion_busy_flag === 1'h1 && span < 5000) begin
            span++;
            @(negedge sys_clk);
        end
    endtask : convert
    task automatic report_and_stop;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : report_and_stop

    // ******************************
    // test sequence
    // ******************************
    initial begin
        repeat (4) @(negedge sys_clk);
        reset_n = 1'h1;
        chk("reset", {2'h0, conversion_busy_flag, converter_interrupt_flag, result_high_byte, result_low_byte}, 20'h0);
        converter_power_enable = 1'h1;
        global_interrupt_enable = 1'h1;
        converter_interrupt_enable = 1'h1;
        for (int i = 0; i < 8; i++) begin
            conv_clock_divider_sel = i[2:0];
            input_source_sel = (i[1:0] == 2'h0) ? 3'h0 : {1'h1, i[1:0]};
            external_channel_sel = {1'h0, i[2:0]};
            result_format_sel = i[0];
            clear_flag();
            convert();
            chk("span", 20'(span), 20'(16 << i));
            chk("result", {4'h0, result_high_byte, result_low_byte}, {4'h0, aligned({i[2:0], 9'h1ff}, i[0])});
            chk("irq", {18'h0, converter_interrupt_flag, interrupt_request}, 20'h3);
        end
        converter_interrupt_enable = 1'h0;
        @(negedge sys_clk);
        chk("mask", {18'h0, converter_interrupt_flag, interrupt_request}, 20'h2);
        converter_interrupt_enable = 1'h1;
        global_interrupt_enable = 1'h0;
        @(negedge sys_clk);
        chk("global mask", {18'h0, converter_interrupt_flag, interrupt_request}, 20'h2);
        clear_flag();
        chk("clear", {19'h0, converter_interrupt_flag}, 20'h0);
        conv_clock_divider_sel = 3'h0;
        external_channel_sel = 4'h8;
        input_source_sel = 3'h1;
        result_format_sel = 1'h0;
        pulse();
        repeat (4) @(negedge sys_clk);
        pulse();
        repeat (12) @(negedge sys_clk);
        chk("restart", {19'h0, conversion_busy_flag}, 20'h0);
        chk("bandgap", {4'h0, result_high_byte, result_low_byte}, {4'h0, aligned(BG, 1'h0)});
        clear_flag();
        conv_clock_divider_sel = 3'h1;
        input_source_sel = 3'h0;
        external_channel_sel = 4'h3;
        pulse();
        repeat (6) @(negedge sys_clk);
        converter_power_enable = 1'h0;
        repeat (3) @(negedge sys_clk);
        chk("abort", {1'h0, converter_interrupt_flag, conversion_busy_flag, converter_powered, result_high_byte, result_low_byte}, {4'h0, aligned(BG, 1'h0)});
        pulse();
        repeat (4) @(negedge sys_clk);
        chk("off", {19'h0, conversion_busy_flag}, 20'h0);
        report_and_stop();
    end

    // tests need about 4200 cycles of 4 ns
    initial begin
        #100000;
        n_errors++;
        report_and_stop();
    end
endmodule : adc_conversion_sequencer_tb
